/* File: pao_pkg.sv */
// Constants, register map and state types for the PCI arbiter observation block
package pao_pkg;

  // Register byte addresses on the Wishbone slave
  localparam int PAO_ADR_W = 16;
  localparam logic [15:0] PAO_CFG_ADR = 16'hd100;
  localparam logic [15:0] PAO_BROKEN_ADR = 16'hd110;
  localparam logic [15:0] PAO_REQ_ADR = 16'hd114;
  localparam logic [15:0] PAO_GNT_ADR = 16'hd118;
  localparam logic [15:0] PAO_STATE_ADR = 16'hd11c;

  // Field positions
  localparam int PAO_CFG_CHK_BIT = 0;
  localparam int PAO_CFG_EN_BIT = 1;
  localparam int PAO_CFG_PARK_BIT = 3;
  localparam int PAO_BROKEN_TOP_BIT = 7;
  localparam int PAO_INT_BIT = 7;
  localparam int PAO_SEL_BIT = 7;
  localparam int PAO_EXT_N = 4;

  // Master indices: 0..3 external ports A..D, 4 the internal controller
  localparam logic [2:0] PAO_IDX_PORT_A = 3'h0;
  localparam logic [2:0] PAO_IDX_INT = 3'h4;
  localparam int PAO_MASTERS = 5;

  // Reset values
  localparam logic [7:0] PAO_REQ_RST = 8'h00;
  localparam logic [7:0] PAO_GNT_RST = 8'h80;
  localparam logic PAO_SEL_RST = 1'b0;

  // Cycles a granted, requesting master may leave the bus idle before it is judged broken
  localparam logic [4:0] PAO_BM_WAIT_CYC = 5'h10;

  typedef enum logic [1:0] {
    PAO_L1_PARK,
    PAO_L1_OWN,
    PAO_L1_TURN
  } pao_l1_e;

  typedef struct packed {
    logic [7:0] req;
    logic [7:0] gnt;
    pao_l1_e l1;
    logic [2:0] rr;
    logic [2:0] pend;
    logic sel;
    logic en;
    logic park;
    logic chk;
    logic [3:0] broken;
    logic [4:0] wcnt;
    logic ack;
    logic [31:0] dat;
  } pao_state_s;

  localparam pao_state_s PAO_RST = '{
    req: PAO_REQ_RST,
    gnt: PAO_GNT_RST,
    l1: PAO_L1_PARK,
    rr: PAO_IDX_INT,
    pend: PAO_IDX_INT,
    sel: PAO_SEL_RST,
    en: 1'b0,
    park: 1'b0,
    chk: 1'b0,
    broken: 4'h0,
    wcnt: 5'h00,
    ack: 1'b0,
    dat: 32'h0000_0000
  };

endpackage

/* File: pao_arbiter.sv */
// PCI bus arbiter with diagnostic request, grant and state observation registers
`timescale 1ns/1ps

module pao_arbiter
  import pao_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [15:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic int_req_in,
  output logic int_gnt_out,
  input wire logic [3:0] pci_req_n_in,
  output logic [3:0] pci_gnt_n_out,
  input wire logic pci_frame_n_in,
  input wire logic pci_irdy_n_in
);

  pao_state_s q;
  pao_state_s d;

  logic idle;
  logic [3:0] ext_ok;
  logic [4:0] cand;
  logic [2:0] tgt;
  logic [2:0] turn_tgt;
  logic wr_hit;

  // Rotating priority: the search starts just after the last winner
  function automatic logic [2:0] pao_pick(input logic [4:0] c, input logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] res;
    logic found;
    res = last;
    found = 1'b0;
    for (int k = 1; k <= PAO_MASTERS; k++) begin
      idx = 3'((int'(last) + k) % PAO_MASTERS);
      if (!found && c[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] pao_onehot(input logic [2:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i == PAO_IDX_INT) begin
      v[PAO_INT_BIT] = 1'b1;
    end else begin
      v[i[1:0]] = 1'b1;
    end
    return v;
  endfunction

  always_comb begin
    d = q;
    idle = pci_frame_n_in & pci_irdy_n_in;
    ext_ok = ~pci_req_n_in & ~q.broken & {PAO_EXT_N{q.en}};
    cand = {int_req_in, ext_ok};
    tgt = PAO_IDX_INT;
    turn_tgt = q.pend;
    wr_hit = 1'b0;

    d.req = PAO_REQ_RST;
    d.req[PAO_INT_BIT] = int_req_in;
    d.req[PAO_EXT_N-1:0] = ~pci_req_n_in;

    // Bus slave: ack one cycle after the strobe, dropped the cycle after
    d.ack = wb_cyc_in & wb_stb_in & ~q.ack;
    if (d.ack && !wb_we_in) begin
      d.dat = 32'h0000_0000;
      case (wb_adr_in)
        PAO_CFG_ADR: begin
          d.dat[PAO_CFG_CHK_BIT] = q.chk;
          d.dat[PAO_CFG_EN_BIT] = q.en;
          d.dat[PAO_CFG_PARK_BIT] = q.park;
        end
        PAO_BROKEN_ADR: begin
          for (int i = 0; i < PAO_EXT_N; i++) begin
            d.dat[PAO_BROKEN_TOP_BIT-i] = q.broken[i];
          end
        end
        PAO_REQ_ADR: d.dat[7:0] = q.req;
        PAO_GNT_ADR: d.dat[7:0] = q.gnt;
        PAO_STATE_ADR: begin
          d.dat[PAO_SEL_BIT] = q.sel;
          // Level 1 shows the sequencing state, level 2 the rotating priority pointer
          d.dat[4:0] = q.sel ? {3'h0, q.l1} : {2'h0, q.rr};
        end
        default: d.dat = 32'h0000_0000;
      endcase
    end

    wr_hit = d.ack & wb_we_in & wb_sel_in[0];
    if (wr_hit) begin
      case (wb_adr_in)
        PAO_CFG_ADR: begin
          d.chk = wb_dat_in[PAO_CFG_CHK_BIT];
          d.en = wb_dat_in[PAO_CFG_EN_BIT];
          d.park = wb_dat_in[PAO_CFG_PARK_BIT];
        end
        PAO_BROKEN_ADR: begin
          for (int i = 0; i < PAO_EXT_N; i++) begin
            d.broken[i] = wb_dat_in[PAO_BROKEN_TOP_BIT-i];
          end
        end
        PAO_STATE_ADR: d.sel = wb_dat_in[PAO_SEL_BIT];
        // Live snapshots cannot be overwritten, so a stray write does not corrupt diagnosis
        default: d.sel = d.sel;
      endcase
    end

    case (q.l1)
      PAO_L1_TURN: begin
        // Re-check the pending master: software may have disabled or flagged it meanwhile
        turn_tgt = q.pend;
        if (turn_tgt != PAO_IDX_INT && (!q.en || q.broken[turn_tgt[1:0]])) begin
          turn_tgt = PAO_IDX_INT;
        end
        d.gnt = pao_onehot(turn_tgt);
        d.rr = turn_tgt;
        d.l1 = cand[turn_tgt] ? PAO_L1_OWN : PAO_L1_PARK;
      end
      PAO_L1_PARK, PAO_L1_OWN: begin
        if (idle) begin
          if (cand != 5'h00) begin
            tgt = pao_pick(cand, q.rr);
          end else if (q.park && q.en && !q.broken[0]) begin
            tgt = PAO_IDX_PORT_A;
          end else if (!q.park && (q.gnt[PAO_INT_BIT] || (q.en && (q.gnt[3:0] & ~q.broken) != 4'h0))) begin
            tgt = q.rr;
          end else begin
            tgt = PAO_IDX_INT;
          end
          if (pao_onehot(tgt) == q.gnt) begin
            d.l1 = cand[tgt] ? PAO_L1_OWN : PAO_L1_PARK;
          end else begin
            // One dead cycle between owners avoids two masters driving the bus
            d.gnt = 8'h00;
            d.pend = tgt;
            d.l1 = PAO_L1_TURN;
          end
        end
      end
      default: begin
        d.gnt = PAO_GNT_RST;
        d.l1 = PAO_L1_PARK;
      end
    endcase

    // Broken master check: granted, requesting, yet the bus stays idle too long
    if (q.chk && q.l1 == PAO_L1_OWN && q.rr != PAO_IDX_INT && idle && !pci_req_n_in[q.rr[1:0]]) begin
      d.wcnt = q.wcnt + 5'h01;
      if (q.wcnt == PAO_BM_WAIT_CYC - 5'h01) begin
        d.broken[q.rr[1:0]] = 1'b1;
        d.wcnt = 5'h00;
      end
    end else begin
      d.wcnt = 5'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= PAO_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_out = q.dat;
  assign wb_ack_out = q.ack;
  assign int_gnt_out = q.gnt[PAO_INT_BIT];
  assign pci_gnt_n_out = ~q.gnt[3:0];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_write(logic [15:0] a);
    wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] && wb_adr_in == a && !wb_ack_out ##1 wb_ack_out;
  endsequence

  sequence s_read(logic [15:0] a);
    wb_cyc_in && wb_stb_in && !wb_we_in && wb_adr_in == a && !wb_ack_out ##1 wb_ack_out;
  endsequence

  property p_req_live;
    @(posedge clk_in) disable iff (rst_in)
    !$past(rst_in) |-> q.req == {$past(int_req_in), 3'h0, ~$past(pci_req_n_in)};
  endproperty
  a_req_live: assert property (p_req_live) else $error("request snapshot does not follow inputs");

  property p_req_reset;
    @(posedge clk_in) disable iff (1'b0)
    rst_in ##1 !rst_in |-> q.req == PAO_REQ_RST
      ##1 (rst_in || q.req == {$past(int_req_in), 3'h0, ~$past(pci_req_n_in)});
  endproperty
  a_req_reset: assert property (p_req_reset) else $error("request snapshot not zero after reset");

  property p_gnt_read;
    s_read(PAO_GNT_ADR) |-> wb_dat_out == {24'h0, $past(q.gnt)} && pci_gnt_n_out == ~q.gnt[3:0];
  endproperty
  a_gnt_read: assert property (p_gnt_read) else $error("grant snapshot read mismatch");

  property p_gnt_reset;
    @(posedge clk_in) disable iff (1'b0)
    rst_in |=> int_gnt_out && pci_gnt_n_out == 4'hf;
  endproperty
  a_gnt_reset: assert property (p_gnt_reset) else $error("grant not parked on internal after reset");

  property p_sel_write;
    s_write(PAO_STATE_ADR) |-> ##1 q.sel == $past(wb_dat_in[PAO_SEL_BIT], 2);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("observe select not written");

  property p_snap_ro;
    s_write(PAO_REQ_ADR) |-> ##1 q.req == {$past(int_req_in), 3'h0, ~$past(pci_req_n_in)};
  endproperty
  a_snap_ro: assert property (p_snap_ro) else $error("write altered request snapshot");

  property p_disabled_no_ext;
    !q.en && !$past(q.en) |-> pci_gnt_n_out == 4'hf || $past(q.gnt[3:0] != 4'h0);
  endproperty
  a_disabled_no_ext: assert property (p_disabled_no_ext) else $error("external grant while disabled");

  property p_park_a;
    (q.en && q.park && !q.broken[0] && !int_req_in && pci_req_n_in == 4'hf && idle)[*3]
      |-> ##[0:2] !pci_gnt_n_out[0];
  endproperty
  a_park_a: assert property (p_park_a) else $error("port A not parked");

  property p_broken_excluded;
    $rose(q.gnt[0]) |-> !$past(q.broken[0]);
  endproperty
  a_broken_excluded: assert property (p_broken_excluded) else $error("broken master granted");

  property p_state_view;
    s_read(PAO_STATE_ADR) |-> wb_dat_out[4:0] == ($past(q.sel) ? {3'h0, $past(q.l1)} : {2'h0, $past(q.rr)});
  endproperty
  a_state_view: assert property (p_state_view) else $error("state view encoding wrong");

  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus acknowledge longer than one cycle");

  property p_one_grant;
    q.gnt[6:4] == 3'h0 && $onehot0({q.gnt[PAO_INT_BIT], q.gnt[3:0]});
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("more than one grant active");

  property p_dead_cycle;
    q.gnt != 8'h00 && $past(q.gnt) != 8'h00 |-> q.gnt == $past(q.gnt);
  endproperty
  a_dead_cycle: assert property (p_dead_cycle) else $error("grant moved without a dead cycle");

  property p_ext_needs_en;
    q.gnt[3:0] != 4'h0 && $past(q.gnt[3:0]) == 4'h0 |-> $past(q.en);
  endproperty
  a_ext_needs_en: assert property (p_ext_needs_en) else $error("external grant issued while disabled");

  property p_broken_any;
    (q.gnt[3:0] & ~$past(q.gnt[3:0]) & $past(q.broken)) == 4'h0;
  endproperty
  a_broken_any: assert property (p_broken_any) else $error("flagged master granted");

  property p_sel_hold;
    !$past(wr_hit && wb_adr_in == PAO_STATE_ADR) |-> q.sel == $past(q.sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("observe select changed without a write");

  sequence s_bm_expire;
    q.chk && q.l1 == PAO_L1_OWN && q.rr != PAO_IDX_INT && idle && !pci_req_n_in[q.rr[1:0]]
      && q.wcnt == PAO_BM_WAIT_CYC - 5'h01;
  endsequence

  property p_bm_flag;
    s_bm_expire |=> q.broken[$past(q.rr[1:0])];
  endproperty
  a_bm_flag: assert property (p_bm_flag) else $error("idle owner not flagged broken");

  property p_wcnt_cap;
    q.wcnt < PAO_BM_WAIT_CYC;
  endproperty
  a_wcnt_cap: assert property (p_wcnt_cap) else $error("broken wait counter overran");

endmodule

/* File: pao_masters.sv */
// Far-side model: four external PCI masters and the internal controller
`timescale 1ns/1ps
module pao_masters #(parameter int LEN = 3) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [4:0] want_in,
  input wire logic [3:0] dead_in,
  input wire logic int_gnt_in,
  input wire logic [3:0] gnt_n_in,
  output logic int_req_out,
  output logic [3:0] req_n_out,
  output logic frame_n_out,
  output logic irdy_n_out
);
  int cnt_q;
  // Burst starts on the clock edge after the grant is seen; a dead master requests but never drives the bus
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 0;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end else if (|(~gnt_n_in & want_in[3:0] & ~dead_in) || (int_gnt_in && want_in[4])) begin
      cnt_q <= LEN;
    end
  end
  assign int_req_out = want_in[4];
  assign req_n_out = ~want_in[3:0];
  assign frame_n_out = !(cnt_q > 1);
  assign irdy_n_out = (cnt_q == 0);
endmodule

/* File: pci_arbiter_observation_test.sv */
// Self-checking bench for the arbiter observation registers
`timescale 1ns/1ps
module pci_arbiter_observation_test;
  import pao_pkg::*;
  logic clk_in = 0;
  logic rst_in = 1;
  logic cyc = 0, stb = 0, we = 0;
  logic [15:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, wb_dat_out;
  logic wb_ack_out, int_gnt_out, int_req, frame_n, irdy_n;
  logic [3:0] req_n, pci_gnt_n_out;
  logic [4:0] want = '0;
  logic [3:0] dead = '0;
  int failures = 0, tests_run = 0;

  initial forever #50 clk_in = ~clk_in;

  pao_arbiter uut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .int_req_in(int_req), .int_gnt_out(int_gnt_out), .pci_req_n_in(req_n), .pci_gnt_n_out(pci_gnt_n_out),
    .pci_frame_n_in(frame_n), .pci_irdy_n_in(irdy_n));
  pao_masters #(.LEN(3)) masters (.clk_in(clk_in), .rst_in(rst_in), .want_in(want), .dead_in(dead),
    .int_gnt_in(int_gnt_out), .gnt_n_in(pci_gnt_n_out), .int_req_out(int_req), .req_n_out(req_n),
    .frame_n_out(frame_n), .irdy_n_out(irdy_n));

  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rdat = wb_dat_out;
    cyc <= 0; stb <= 0;
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
  endtask

  // Grant pins as the snapshot layout: bit 7 internal, bits 3:0 external
  function automatic logic [31:0] pins();
    return {24'h0, int_gnt_out, 3'h0, ~pci_gnt_n_out};
  endfunction

  task wait_gnt(input logic [31:0] exp);
    int n;
    n = 0;
    while (pins() !== exp && n < 60) begin
      @(posedge clk_in);
      n++;
    end
    chk(pins(), exp);
    if (pins() !== exp) give_verdict();
  endtask

  initial begin
    void'($urandom(66637));
    repeat (12) @(posedge clk_in);
    rst_in <= 0;
    wb(0, PAO_REQ_ADR, 0); chk(rdat, 32'h0);
    wb(0, PAO_GNT_ADR, 0); chk(rdat, 32'h80);
    wb(0, PAO_STATE_ADR, 0); chk(rdat & 32'h80, 32'h0);
    // Arbiter still disabled: random request levels must show but external ones never win
    repeat (8) begin
      @(posedge clk_in);
      want <= 5'($urandom);
      repeat (3) @(posedge clk_in);
      wb(0, PAO_REQ_ADR, 0); chk(rdat, {24'h0, want[4], 3'h0, want[3:0]});
      chk(pins(), 32'h80);
    end
    wb(0, PAO_GNT_ADR, 0); chk(rdat, 32'h80);
    want <= 5'h02;
    wb(1, PAO_CFG_ADR, 32'h02);
    wait_gnt(32'h02);
    wb(0, PAO_GNT_ADR, 0); chk(rdat, 32'h02);
    wb(1, PAO_STATE_ADR, 32'h80);
    wb(0, PAO_STATE_ADR, 0); chk(rdat & 32'h80, 32'h80);
    chk(32'(rdat[4:0] <= 5'h2), 32'h1);
    wb(1, PAO_STATE_ADR, 32'h0);
    wb(0, PAO_STATE_ADR, 0); chk(rdat, 32'h01);
    want <= 5'h00;
    wb(1, PAO_CFG_ADR, 32'h0a);
    wait_gnt(32'h01);
    wb(1, PAO_BROKEN_ADR, 32'h80);
    want <= 5'h01;
    wait_gnt(32'h80);
    repeat (30) @(posedge clk_in);
    chk(pins(), 32'h80);
    want <= 5'h04;
    wait_gnt(32'h04);
    wb(0, 16'hd104, 0); chk(rdat, 32'h0);
    wb(1, PAO_REQ_ADR, 32'hff);
    wb(0, PAO_REQ_ADR, 0); chk(rdat, 32'h04);
    // Port D requests but never drives the bus, so the check must flag it
    want <= 5'h08;
    dead <= 4'h8;
    wb(1, PAO_CFG_ADR, 32'h03);
    wb(0, PAO_CFG_ADR, 0);
    chk(rdat, 32'h03);
    wait_gnt(32'h08);
    wait_gnt(32'h80);
    wb(0, PAO_BROKEN_ADR, 0);
    chk(rdat, 32'h90);
    give_verdict();
  end
endmodule
